// ==== hdl/dtu_delay_trigger_unit.sv ====
// programmable delay counter pacing paired converter sample triggers
`timescale 1ns/10ps
`include "dtu_defs.svh"
module dtu_delay_trigger_unit #(
	parameter int NCH = 4
) (
	input  wire logic               core_clk,
	input  wire logic               sys_rst,
	input  wire dtu_pkg::dtu_req_t  bus_req,
	output logic [31:0]             bus_rdata,
	input  wire logic [NCH-1:0]     conv_done,
	output logic [NCH-1:0]          arm_pulse_first,
	output logic [NCH-1:0]          arm_pulse_second,
	output logic [NCH-1:0]          result_sel_second,
	output logic [NCH-1:0]          conv_busy,
	output logic                    irq,
	output logic                    fault_irq
);
	import dtu_pkg::*;

	localparam int CONV_CYC = `DTU_CONV_CYC;

	// all checks below run on the core clock, quiet during reset
	default clocking dtu_cb @(posedge core_clk);
	endclocking
	default disable iff (sys_rst);

	dtu_state_t               state_r;
	logic [15:0]              count_r;
	logic [15:0]              mod_r;
	logic [15:0]              idly_r;
	logic                     en_r;
	logic                     cont_r;
	logic                     irqen_r;
	logic                     status_r;
	logic                     irq_en_r;
	logic [NCH-1:0]           fault_first_r;
	logic [NCH-1:0]           fault_second_r;
	logic [NCH-1:0]           done_s1_r;
	logic [NCH-1:0]           done_s2_r;
	logic [NCH-1:0]           done_s3_r;
	logic [15:0]              dly_first_r  [NCH];
	logic [15:0]              dly_second_r [NCH];
	logic [NCH-1:0]           fire_first;
	logic [NCH-1:0]           fire_second;
	logic [NCH-1:0]           done_pulse;
	logic                     counting;
	logic                     at_mod;
	logic                     idly_hit;
	logic                     wr_ctrl;
	logic                     sw_start;

	assign wr_ctrl  = bus_req.wr && bus_req.addr == `DTU_OFF_CTRL;
	assign sw_start = wr_ctrl && bus_req.wdata[`DTU_BIT_SWTRIG]
		&& bus_req.wdata[`DTU_BIT_EN];
	assign counting = state_r != DTU_IDLE;
	assign at_mod   = counting && count_r == mod_r;
	assign idly_hit = counting && en_r && count_r == idly_r;

	// converter done lines cross from the converter domain
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			done_s1_r <= '0;
			done_s2_r <= '0;
			done_s3_r <= '0;
		end
		else
		begin
			done_s1_r <= conv_done;
			done_s2_r <= done_s1_r;
			done_s3_r <= done_s2_r;
		end
	end
	assign done_pulse = done_s2_r & ~done_s3_r;

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			en_r    <= 1'b0;
			cont_r  <= 1'b0;
			irqen_r <= 1'b0;
			mod_r   <= `DTU_MOD_RST;
			idly_r  <= `DTU_IDLY_RST;
			irq_en_r <= 1'b0;
		end
		else if (bus_req.wr)
		begin
			unique case (bus_req.addr)
				`DTU_OFF_CTRL:
				begin
					en_r    <= bus_req.wdata[`DTU_BIT_EN];
					cont_r  <= bus_req.wdata[`DTU_BIT_CONT];
					irqen_r <= bus_req.wdata[`DTU_BIT_IRQEN];
				end
				`DTU_OFF_MOD:   mod_r  <= bus_req.wdata[15:0];
				`DTU_OFF_IDLY:  idly_r <= bus_req.wdata[15:0];
				`DTU_OFF_IRQEN: irq_en_r <= bus_req.wdata[0];
				default:        ;
			endcase
		end
	end

	// counter sequencing
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			state_r <= DTU_IDLE;
			count_r <= 16'h0000;
		end
		else if (!en_r && !sw_start)
		begin
			state_r <= DTU_IDLE;
			count_r <= 16'h0000;
		end
		else
		begin
			unique case (state_r)
				DTU_IDLE:
				begin
					count_r <= 16'h0000;
					if (sw_start)
						state_r <= DTU_RUN;
				end
				DTU_RUN:
				begin
					if (at_mod)
					begin
						count_r <= 16'h0000;
						state_r <= DTU_WRAP;
					end
					else
						count_r <= count_r + 16'h0001;
				end
				DTU_WRAP:
				begin
					state_r <= cont_r ? DTU_RUN : DTU_IDLE;
					count_r <= 16'h0000;
				end
				default: state_r <= DTU_IDLE;
			endcase
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_ch
			logic [15:0] cnt_conv_r;

			always_ff @(posedge core_clk)
			begin
				if (sys_rst)
				begin
					dly_first_r[g]  <= 16'h0000;
					dly_second_r[g] <= 16'h0000;
				end
				else if (bus_req.wr
					&& bus_req.addr == `DTU_OFF_DLY_BASE + 8'(g * 8))
					dly_first_r[g] <= bus_req.wdata[15:0];
				else if (bus_req.wr
					&& bus_req.addr == `DTU_OFF_DLY_BASE + 8'(g * 8 + 4))
					dly_second_r[g] <= bus_req.wdata[15:0];
			end

			assign fire_first[g] = state_r == DTU_RUN
				&& count_r == dly_first_r[g];
			assign fire_second[g] = state_r == DTU_RUN
				&& count_r == dly_second_r[g];

			always_ff @(posedge core_clk)
			begin
				if (sys_rst)
				begin
					arm_pulse_first[g]   <= 1'b0;
					arm_pulse_second[g]  <= 1'b0;
					result_sel_second[g] <= 1'b0;
				end
				else
				begin
					arm_pulse_first[g]  <= fire_first[g];
					arm_pulse_second[g] <= fire_second[g];
					// route next result to first or second
					if (fire_first[g])
						result_sel_second[g] <= 1'b0;
					else if (fire_second[g])
						result_sel_second[g] <= 1'b1;
				end
			end

			// busy from a trigger until done or worst-case time elapses
			always_ff @(posedge core_clk)
			begin
				if (sys_rst)
				begin
					conv_busy[g] <= 1'b0;
					cnt_conv_r   <= 16'h0000;
				end
				else if ((fire_first[g] || fire_second[g]) && !conv_busy[g])
				begin
					conv_busy[g] <= 1'b1;
					cnt_conv_r   <= 16'(CONV_CYC);
				end
				else if (conv_busy[g])
				begin
					if (done_pulse[g] || cnt_conv_r == 16'h0001)
						conv_busy[g] <= 1'b0;
					cnt_conv_r <= cnt_conv_r - 16'h0001;
				end
			end

			always_ff @(posedge core_clk)
			begin
				if (sys_rst)
				begin
					fault_first_r[g]  <= 1'b0;
					fault_second_r[g] <= 1'b0;
				end
				else
				begin
					if (fire_first[g] && conv_busy[g])
						fault_first_r[g] <= 1'b1;
					else if (bus_req.wr && bus_req.addr == `DTU_OFF_FCLR
						&& bus_req.wdata[g])
						fault_first_r[g] <= 1'b0;
					if (fire_second[g] && conv_busy[g])
						fault_second_r[g] <= 1'b1;
					else if (bus_req.wr && bus_req.addr == `DTU_OFF_FCLR
						&& bus_req.wdata[NCH + g])
						fault_second_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// sticky counter event; set wins over the write-one clear
	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			status_r <= 1'b0;
		else if (idly_hit && irqen_r)
			status_r <= 1'b1;
		else if (bus_req.wr && bus_req.addr == `DTU_OFF_CLEAR
			&& bus_req.wdata[0])
			status_r <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
		begin
			irq       <= 1'b0;
			fault_irq <= 1'b0;
		end
		else
		begin
			irq       <= status_r && irq_en_r;
			// no mask on the fault line
			fault_irq <= |{fault_first_r, fault_second_r};
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (sys_rst)
			bus_rdata <= 32'h0000_0000;
		else if (bus_req.rd)
		begin
			bus_rdata <= 32'h0000_0000;
			unique case (bus_req.addr)
				`DTU_OFF_CTRL:   bus_rdata[2:0] <= {irqen_r, cont_r, en_r};
				`DTU_OFF_MOD:    bus_rdata[15:0] <= mod_r;
				`DTU_OFF_IDLY:   bus_rdata[15:0] <= idly_r;
				`DTU_OFF_STATUS: bus_rdata[0] <= status_r;
				`DTU_OFF_IRQEN:  bus_rdata[0] <= irq_en_r;
				`DTU_OFF_COUNT:  bus_rdata[15:0] <= count_r;
				`DTU_OFF_FAULT:
					bus_rdata[2*NCH-1:0] <= {fault_second_r, fault_first_r};
				default:
				begin
					for (int i = 0; i < NCH; i++)
					begin
						if (bus_req.addr == `DTU_OFF_DLY_BASE + 8'(i * 8))
							bus_rdata[15:0] <= dly_first_r[i];
						if (bus_req.addr == `DTU_OFF_DLY_BASE + 8'(i * 8 + 4))
							bus_rdata[15:0] <= dly_second_r[i];
					end
				end
			endcase
		end
	end

	a_fault_set: assert property (
		fire_first[0] && conv_busy[0] |=> fault_first_r[0])
		else $error("fault not set");
	// early second pre-trigger flags the fault
	a_fault_late: assert property (
		fire_second[0] && conv_busy[0] |=> fault_second_r[0])
		else $error("second fault not set");
	a_fault_irq: assert property (
		fault_first_r[0] || fault_second_r[0] |=> fault_irq)
		else $error("fault irq missing");
	a_first_start: assert property (
		state_r == DTU_RUN && count_r == 16'h0 && dly_first_r[0] == 16'h0
		|=> arm_pulse_first[0])
		else $error("first pulse missing");
	a_wrap_zero: assert property (
		state_r == DTU_RUN && at_mod && en_r |=> count_r == 16'h0)
		else $error("no wrap");
	a_cont_run: assert property (
		state_r == DTU_WRAP && cont_r && en_r |=> state_r == DTU_RUN)
		else $error("continuous stopped");
	a_sel_second: assert property (
		fire_second[0] && !fire_first[0] |=> result_sel_second[0])
		else $error("select wrong");
	a_idly_stat: assert property (
		idly_hit && irqen_r |=> status_r ##1 (irq == $past(irq_en_r)))
		else $error("status not set");
	a_busy_bound: assert property (
		$rose(conv_busy[0]) |-> ##[1:300] !conv_busy[0])
		else $error("busy too long");
	c_fault: cover property (@(posedge core_clk) fault_irq);
	c_wrap: cover property (@(posedge core_clk) state_r == DTU_WRAP);
	c_irq: cover property (@(posedge core_clk) irq);
endmodule : dtu_delay_trigger_unit

// ==== hdl/dtu_defs.svh ====
// offsets, field positions, reset values and timing counts of the delay trigger unit
`ifndef DTU_DEFS_SVH
`define DTU_DEFS_SVH
`define DTU_OFF_CTRL      8'h00
`define DTU_OFF_MOD       8'h04
`define DTU_OFF_IDLY      8'h08
`define DTU_OFF_STATUS    8'h0c
`define DTU_OFF_CLEAR     8'h10
`define DTU_OFF_IRQEN     8'h14
`define DTU_OFF_COUNT     8'h18
`define DTU_OFF_FAULT     8'h1c
`define DTU_OFF_FCLR      8'h20
`define DTU_OFF_DLY_BASE  8'h40
`define DTU_BIT_EN        0
`define DTU_BIT_CONT      1
`define DTU_BIT_IRQEN     2
`define DTU_BIT_SWTRIG    3
`define DTU_MOD_RST       16'h1f00
`define DTU_IDLY_RST      16'h0000
`define DTU_CONV_TIME_NS  12050
`define DTU_CLK_NS        50
`define DTU_CONV_CYC      ((`DTU_CONV_TIME_NS + `DTU_CLK_NS - 1) / `DTU_CLK_NS)
`endif

// ==== hdl/dtu_pkg.sv ====
// types of the delay trigger unit
package dtu_pkg;
	typedef enum logic [1:0]
	{
		DTU_IDLE = 2'b00,
		DTU_RUN  = 2'b01,
		DTU_WRAP = 2'b11
	} dtu_state_t;
	typedef struct packed
	{
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} dtu_req_t;
endpackage : dtu_pkg

// ==== dv/dtu_conv_model.sv ====
// converter model answering the most recent arm pulse with a done pulse
`timescale 1ns/10ps
module dtu_conv_model #(
	parameter int NCH  = 4,
	parameter int FAST = 10,
	parameter int SLOW = 100
) (
	input  wire logic           core_clk,
	input  wire logic           sys_rst,
	input  wire logic [NCH-1:0] arm_pulse_first,
	input  wire logic [NCH-1:0] arm_pulse_second,
	input  wire logic           slow,
	output logic [NCH-1:0]      conv_done
);
	int left_r [NCH];
	always_ff @(posedge core_clk)
	begin
		for (int i = 0; i < NCH; i++)
		begin
			conv_done[i] <= (left_r[i] == 1);
			if (sys_rst)
				left_r[i] <= 0;
			else if (arm_pulse_first[i] | arm_pulse_second[i])
				left_r[i] <= slow ? SLOW : FAST;
			else if (left_r[i] > 0)
				left_r[i] <= left_r[i] - 1;
		end
	end
endmodule : dtu_conv_model

// ==== dv/tb_top.sv ====
// self-checking bench of the delay trigger unit
`timescale 1ns/10ps
`include "dtu_defs.svh"
module tb_top;
	import dtu_pkg::*;
	logic              core_clk;
	logic              sys_rst;
	dtu_req_t          bus_req;
	logic [31:0]       bus_rdata;
	logic [3:0]        conv_done;
	logic [3:0]        arm_pulse_first;
	logic [3:0]        arm_pulse_second;
	logic [3:0]        result_sel_second;
	logic [3:0]        conv_busy;
	logic              irq;
	logic              fault_irq;
	logic              slow;
	int                miscompares;
	int                checked;
	int                n;

	dtu_delay_trigger_unit #(.NCH(4)) dut (
		.core_clk          (core_clk),
		.sys_rst           (sys_rst),
		.bus_req           (bus_req),
		.bus_rdata         (bus_rdata),
		.conv_done         (conv_done),
		.arm_pulse_first   (arm_pulse_first),
		.arm_pulse_second  (arm_pulse_second),
		.result_sel_second (result_sel_second),
		.conv_busy         (conv_busy),
		.irq               (irq),
		.fault_irq         (fault_irq)
	);
	dtu_conv_model #(.NCH(4)) conv (
		.core_clk         (core_clk),
		.sys_rst          (sys_rst),
		.arm_pulse_first  (arm_pulse_first),
		.arm_pulse_second (arm_pulse_second),
		.slow             (slow),
		.conv_done        (conv_done)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		#1;
		chk("rdata", e, bus_rdata);
	endtask : rd

	// bounded wait: arm first, arm second, irq, fault irq
	task automatic wait_on(input int sel, input int lim, output int cnt);
		logic s;
		cnt = 0;
		do
		begin
			@(posedge core_clk);
			#1;
			cnt++;
			s = (sel == 0) ? arm_pulse_first[0] :
				(sel == 1) ? arm_pulse_second[0] :
				(sel == 2) ? irq : fault_irq;
		end
		while (s !== 1'b1 && cnt < lim);
		if (s !== 1'b1)
		begin
			miscompares++;
			$display("BAD wait %0d expected 1 seen %b", sel, s);
			print_verdict();
		end
	endtask : wait_on

	initial
	begin
		sys_rst = 1'b1;
		bus_req = '0;
		slow = 1'b0;
		miscompares = 0;
		checked = 0;
		repeat (16) @(posedge core_clk);
		sys_rst <= 1'b0;
		rd(`DTU_OFF_MOD, 32'h1f00);
		rd(`DTU_OFF_IDLY, 32'h0);
		rd(8'h3c, 32'h0);
		wr(`DTU_OFF_MOD, 32'h40);
		wr(`DTU_OFF_IDLY, 32'h30);
		wr(`DTU_OFF_IRQEN, 32'h1);
		// gap of 0x20 covers 3.2 fast conversions
		// second sample sits at count 0x20, about half of the 0x42-cycle period
		for (int c = 0; c < 4; c++)
		begin
			wr(`DTU_OFF_DLY_BASE + 8'(8 * c), 32'h0);
			wr(`DTU_OFF_DLY_BASE + 8'(8 * c + 4), 32'h20);
		end
		wr(`DTU_OFF_CTRL, 32'hf);
		wait_on(0, 20, n);
		chk("first_all", 4'hf, arm_pulse_first);
		chk("busy_set", 4'hf, conv_busy);
		@(posedge core_clk);
		#1;
		chk("sel_first", 4'h0, result_sel_second);
		wait_on(1, 80, n);
		chk("gap", 32'h20, n + 1);
		@(posedge core_clk);
		#1;
		chk("sel_second", 4'hf, result_sel_second);
		wait_on(2, 80, n);
		chk("busy_done", 4'h0, conv_busy);
		rd(`DTU_OFF_STATUS, 32'h1);
		chk("fault_idle", 1'b0, fault_irq);
		wr(`DTU_OFF_CLEAR, 32'h1);
		repeat (3) @(posedge core_clk);
		#1;
		chk("irq_clr", 1'b0, irq);
		slow <= 1'b1;
		for (int c = 0; c < 4; c++)
			wr(`DTU_OFF_DLY_BASE + 8'(8 * c + 4), 32'h4);
		wait_on(0, 80, n);
		wait_on(3, 20, n);
		wr(`DTU_OFF_CTRL, 32'h0);
		rd(`DTU_OFF_FAULT, 32'hf0);
		chk("fault_nomask", 1'b1, fault_irq);
		wr(`DTU_OFF_FCLR, 32'hf0);
		repeat (3) @(posedge core_clk);
		#1;
		chk("fault_clr", 1'b0, fault_irq);
		// second pulse parked past the modulus: next first pulse hits busy
		for (int c = 0; c < 4; c++)
			wr(`DTU_OFF_DLY_BASE + 8'(8 * c + 4), 32'hff);
		wr(`DTU_OFF_CTRL, 32'hf);
		wait_on(3, 200, n);
		wr(`DTU_OFF_CTRL, 32'h0);
		rd(`DTU_OFF_FAULT, 32'h0f);
		wr(`DTU_OFF_FCLR, 32'h0f);
		repeat (3) @(posedge core_clk);
		#1;
		chk("first_clr", 1'b0, fault_irq);
		print_verdict();
	end
endmodule : tb_top
